//--- design/arviq_defines.svh
`ifndef ARVIQ_DEFINES_SVH
`define ARVIQ_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define ARVIQ_OFF_IE     12'h000
`define ARVIQ_OFF_IFG    12'h004
`define ARVIQ_OFF_IV     12'h008
`define ARVIQ_OFF_CTL    12'h00c
`define ARVIQ_OFF_SLOT0  12'h040

// Reset values
`define ARVIQ_RST_IE     16'h0000
`define ARVIQ_RST_IFG    16'h0000
`define ARVIQ_RST_IV     16'h0000
`define ARVIQ_RST_CTL    2'h0

// Control register field positions
`define ARVIQ_CTL_OVIE   3
`define ARVIQ_CTL_TOVIE  2

// Vector codes
`define ARVIQ_IV_NONE    5'h00
`define ARVIQ_IV_OV      5'h01
`define ARVIQ_IV_TOV     5'h02
`define ARVIQ_IV_SLOT0   5'h03

// AXI responses
`define ARVIQ_RESP_OKAY   2'h0
`define ARVIQ_RESP_SLVERR 2'h2

`endif

//--- design/arviq_pkg.sv
package arviq_pkg;
  typedef logic [15:0] arviq_word_t;
  typedef logic [4:0]  arviq_code_t;
endpackage

//--- design/arviq_prio_if.sv
`timescale 1ns/10ps
// Carries pending sources into the priority encoder and the code back
interface arviq_prio_if;
  logic                  ov_req;
  logic                  tov_req;
  logic [15:0]           slot_req;
  arviq_pkg::arviq_code_t code;
  logic                  any;
  modport enc (input ov_req, input tov_req, input slot_req, output code, output any);
  modport top (output ov_req, output tov_req, output slot_req, input code, input any);
endinterface

//--- design/arviq_prio_enc.sv
`timescale 1ns/10ps
`include "arviq_defines.svh"
// Fixed priority: slot overflow, conversion time, then slot 0 down to 15
module arviq_prio_enc
  import arviq_pkg::*;
(
  arviq_prio_if.enc p
);
  always_comb begin
    p.code = `ARVIQ_IV_NONE; // RULE_04
    // Walk from lowest priority up so the last hit wins
    for (int i = 15; i >= 0; i--) begin
      if (p.slot_req[i]) begin
        p.code = 5'(`ARVIQ_IV_SLOT0 + i); // RULE_07
      end
    end
    if (p.tov_req) begin
      p.code = `ARVIQ_IV_TOV; // RULE_06
    end
    if (p.ov_req) begin
      p.code = `ARVIQ_IV_OV; // RULE_05
    end
    p.any = p.ov_req | p.tov_req | (|p.slot_req); // RULE_11
  end
endmodule

//--- design/arviq_top.sv
`timescale 1ns/10ps
`include "arviq_defines.svh"
// Functional notes
// RULE_01: Sixteen read-write slot enable bits, reset 0; 1 lets the slot flag interrupt.
// RULE_02: Slot pending flag sets when a conversion result lands in that slot.
// RULE_03: Flag clears when software reads its slot result, or by writing the flag register.
// RULE_04: Vector reads 000h when nothing is pending.
// RULE_05: Slot overflow reports code 002h, highest priority.
// RULE_06: Conversion time overflow reports code 004h, second priority.
// RULE_07: Slot n reports 006h plus 2n; lower slot wins.
// RULE_08: Vector register read-only, reset 0, code in bits 5 to 1, rest zero.
// RULE_09: Slot overflow interrupts only with its enable and global enable set.
// RULE_10: Conversion time overflow interrupts only with its enable and global enable set.
// RULE_11: Vector shows top enabled pending source; request line high while one exists.
module arviq_top
  import arviq_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] result_load,
  input  wire logic [15:0] result_data [16],
  input  wire logic        slot_overflow,
  input  wire logic        conv_time_overflow,
  input  wire logic        global_irq_enable,
  output logic             irq_req
);
  arviq_word_t ie_q, ie_d, ifg_q, ifg_d;
  logic [1:0]  ctl_q, ctl_d;  // [1] slot overflow enable, [0] conv time enable
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [15:0] rd_clr, wr_clr, wr_set;
  logic        do_wr, do_rd, wr_ok;
  arviq_word_t iv_word;
  arviq_prio_if pif ();

  arviq_prio_enc u_enc (.p(pif));

  // Sources gated by their enables and the processor global enable
  assign pif.ov_req   = slot_overflow & ctl_q[1] & global_irq_enable;      // RULE_09
  assign pif.tov_req  = conv_time_overflow & ctl_q[0] & global_irq_enable; // RULE_10
  assign pif.slot_req = ifg_q & ie_q & {16{global_irq_enable}};           // RULE_01
  assign iv_word      = {10'h000, pif.code, 1'b0};                         // RULE_08
  assign irq_req      = pif.any;                                           // RULE_11

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  assign do_wr = aw_q & w_q & !bv_q;
  assign do_rd = s_axi_arvalid & !rv_q;

  // Bus handshakes; address and data latch independently in either order
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    bv_d  = bv_q;
    rv_d  = rv_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    br_d  = br_q;
    rr_d  = rr_q;
    rd_d  = rd_q;
    wr_ok = 1'b0;
    if (s_axi_awvalid && !aw_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      unique case (awa_q[11:2])
        10'(`ARVIQ_OFF_IE >> 2), 10'(`ARVIQ_OFF_IFG >> 2), 10'(`ARVIQ_OFF_CTL >> 2): wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
      br_d = wr_ok ? `ARVIQ_RESP_OKAY : `ARVIQ_RESP_SLVERR;
    end else if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (do_rd) begin
      rv_d = 1'b1;
      rr_d = `ARVIQ_RESP_OKAY;
      if (s_axi_araddr[11:2] == 10'(`ARVIQ_OFF_IE >> 2)) begin
        rd_d = {16'h0000, ie_q};
      end else if (s_axi_araddr[11:2] == 10'(`ARVIQ_OFF_IFG >> 2)) begin
        rd_d = {16'h0000, ifg_q};
      end else if (s_axi_araddr[11:2] == 10'(`ARVIQ_OFF_IV >> 2)) begin
        rd_d = {16'h0000, iv_word};
      end else if (s_axi_araddr[11:2] == 10'(`ARVIQ_OFF_CTL >> 2)) begin
        rd_d = 32'({ctl_q, 2'b00});
      end else if (s_axi_araddr[11:6] == 6'(`ARVIQ_OFF_SLOT0 >> 6)) begin
        rd_d = {16'h0000, result_data[s_axi_araddr[5:2]]};
      end else begin
        rd_d = 32'h0000_0000;
        rr_d = `ARVIQ_RESP_SLVERR;
      end
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end

  // Flag and enable registers; hardware set beats software clear
  always_comb begin
    rd_clr = 16'h0000;
    wr_clr = 16'h0000;
    wr_set = 16'h0000;
    ie_d   = ie_q;
    ctl_d  = ctl_q;
    if (do_rd && s_axi_araddr[11:6] == 6'(`ARVIQ_OFF_SLOT0 >> 6)) begin
      rd_clr[s_axi_araddr[5:2]] = 1'b1; // RULE_03
    end
    if (do_wr && ws_q[0] && ws_q[1]) begin
      if (awa_q[11:2] == 10'(`ARVIQ_OFF_IE >> 2)) begin
        ie_d = wd_q[15:0]; // RULE_01
      end
      if (awa_q[11:2] == 10'(`ARVIQ_OFF_IFG >> 2)) begin
        wr_clr = ~wd_q[15:0]; // RULE_03
        wr_set = wd_q[15:0];
      end
    end
    if (do_wr && ws_q[0] && awa_q[11:2] == 10'(`ARVIQ_OFF_CTL >> 2)) begin
      ctl_d = {wd_q[`ARVIQ_CTL_OVIE], wd_q[`ARVIQ_CTL_TOVIE]};
    end
    ifg_d = (ifg_q & ~rd_clr & ~wr_clr) | wr_set | result_load; // RULE_02
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q  <= `ARVIQ_RST_IE;
      ifg_q <= `ARVIQ_RST_IFG;
      ctl_q <= `ARVIQ_RST_CTL;
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      bv_q  <= 1'b0;
      rv_q  <= 1'b0;
      awa_q <= 12'h000;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
      br_q  <= 2'h0;
      rr_q  <= 2'h0;
      rd_q  <= 32'h0000_0000;
    end else begin
      ie_q  <= ie_d;
      ifg_q <= ifg_d;
      ctl_q <= ctl_d;
      aw_q  <= aw_d;
      w_q   <= w_d;
      bv_q  <= bv_d;
      rv_q  <= rv_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      br_q  <= br_d;
      rr_q  <= rr_d;
      rd_q  <= rd_d;
    end
  end

  sequence s_slot_read;
    do_rd && s_axi_araddr[11:6] == 6'(`ARVIQ_OFF_SLOT0 >> 6) && !result_load[s_axi_araddr[5:2]];
  endsequence

  // Checked through the encoder so a broken enable gate shows in the vector
  a_enable_gates_slot: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_01
    (ifg_q[0] && !ie_q[0]) |-> iv_word != 16'h0006) else $error("slot code without enable");
  a_load_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_02
    result_load[5] |=> ifg_q[5]) else $error("flag not set by result load");
  a_read_clears_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_03
    s_slot_read |=> !ifg_q[$past(s_axi_araddr[5:2])]) else $error("slot read did not clear flag");
  a_idle_vector_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_04
    !irq_req |-> iv_word == 16'h0000) else $error("vector nonzero when idle");
  a_ov_code_first: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_05
    pif.ov_req |-> iv_word == 16'h0002) else $error("overflow code wrong");
  a_tov_code_second: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_06
    (pif.tov_req && !pif.ov_req) |-> iv_word == 16'h0004) else $error("time overflow code wrong");
  a_slot0_code: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
    (pif.slot_req[0] && !pif.ov_req && !pif.tov_req) |-> iv_word == 16'h0006) else $error("slot 0 code wrong");
  a_slot15_code: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_07
    (pif.slot_req == 16'h8000 && !pif.ov_req && !pif.tov_req) |-> iv_word == 16'h0024) else $error("slot 15 code wrong");
  a_vector_bits_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_08
    iv_word[15:6] == 10'h000 && !iv_word[0]) else $error("vector reserved bits set");
  a_ov_gated: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_09
    (slot_overflow && !(ctl_q[1] && global_irq_enable)) |-> iv_word != 16'h0002) else $error("ov not gated");
  a_tov_gated: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_10
    (conv_time_overflow && !(ctl_q[0] && global_irq_enable)) |-> iv_word != 16'h0004) else $error("tov not gated");
  a_irq_matches: assert property (@(posedge mclk) disable iff (!rst_n) // RULE_11
    irq_req == (|(ifg_q & ie_q) && global_irq_enable || pif.ov_req || pif.tov_req)) else $error("irq mismatch");
endmodule

//--- sim/arviq_cpu_model.sv
`timescale 1ns/10ps
// Processor side: holds the global enable and notes a taken request
module arviq_cpu_model
  import arviq_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic irq_req,
  input  wire logic glob_en_cmd,
  output logic      global_irq_enable,
  output logic      irq_seen
);
  logic en_d, en_q, seen_d, seen_q;
  // Core takes a request only while its enable is set
  always_comb begin
    en_d   = glob_en_cmd;
    seen_d = irq_req & en_q;
  end
  // Enable drops in reset so no stray request is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      en_q   <= en_d;
      seen_q <= seen_d;
    end
  end
  assign global_irq_enable = en_q;
  assign irq_seen          = seen_q;
endmodule

//--- sim/adc_result_irq_vector_tb_top.sv
`timescale 1ns/10ps
`include "arviq_defines.svh"
// Table-driven bench for the interrupt vector block
module adc_result_irq_vector_tb_top
  import arviq_pkg::*;
;
  typedef struct {logic [15:0] ie, ld; logic ov, tov, glob_en; logic [3:0] ctl; logic [15:0] iv; logic irq;} arviq_row_t;
  logic        mclk = 1'b0, rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] result_load = 16'h0;
  arviq_word_t result_data [16];
  logic        slot_overflow = 1'b0, conv_time_overflow = 1'b0, glob_en_cmd = 1'b0;
  logic        global_irq_enable, irq_req, irq_seen;
  int          error_cnt = 0, check_count = 0, cyc = 0;
  arviq_row_t  rows [10] = '{
    '{16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1, 4'h0, 16'h000, 1'b0},
    '{16'hffff, 16'hffff, 1'b1, 1'b1, 1'b1, 4'hc, 16'h002, 1'b1},
    '{16'hffff, 16'hffff, 1'b0, 1'b1, 1'b1, 4'hc, 16'h004, 1'b1},
    '{16'hffff, 16'hffff, 1'b1, 1'b1, 1'b1, 4'h4, 16'h004, 1'b1},
    '{16'hffff, 16'hffff, 1'b1, 1'b1, 1'b1, 4'h0, 16'h006, 1'b1},
    '{16'hfffe, 16'hffff, 1'b0, 1'b0, 1'b1, 4'h0, 16'h008, 1'b1},
    '{16'h8000, 16'hffff, 1'b0, 1'b0, 1'b1, 4'h0, 16'h024, 1'b1},
    '{16'h0000, 16'hffff, 1'b0, 1'b0, 1'b1, 4'h0, 16'h000, 1'b0},
    '{16'hffff, 16'hffff, 1'b1, 1'b1, 1'b0, 4'hc, 16'h000, 1'b0},
    '{16'hffff, 16'h0000, 1'b0, 1'b1, 1'b1, 4'h8, 16'h000, 1'b0}
  };

  arviq_top uut (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .s_axi_awaddr       (s_axi_awaddr),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wdata        (s_axi_wdata),
    .s_axi_wstrb        (s_axi_wstrb),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_araddr       (s_axi_araddr),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rresp        (s_axi_rresp),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .result_load        (result_load),
    .result_data        (result_data),
    .slot_overflow      (slot_overflow),
    .conv_time_overflow (conv_time_overflow),
    .global_irq_enable  (global_irq_enable),
    .irq_req            (irq_req)
  );
  arviq_cpu_model cpu (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .irq_req           (irq_req),
    .glob_en_cmd       (glob_en_cmd),
    .global_irq_enable (global_irq_enable),
    .irq_seen          (irq_seen)
  );

  always #4 mclk = ~mclk;

  // Cut a hung handshake short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data channels are released only at the edge that sees their ready high, the response at the edge that sees bvalid; local flags avoid stale reads
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_left, w_left, b_left;
    aw_left = 1'b1;
    w_left  = 1'b1;
    b_left  = 1'b1;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (b_left) begin
      @(posedge mclk);
      if (aw_left && s_axi_awready === 1'b1) begin
        aw_left        = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready === 1'b1) begin
        w_left        = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b_left        = 1'b0;
        rsp           = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  // Read data and response are taken at the edge where rvalid is seen
  task automatic rdr(input logic [11:0] a);
    logic ar_left, r_left;
    ar_left = 1'b1;
    r_left  = 1'b1;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (r_left) begin
      @(posedge mclk);
      if (ar_left && s_axi_arready === 1'b1) begin
        ar_left        = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        r_left        = 1'b0;
        rd            = s_axi_rdata;
        rsp           = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    foreach (result_data[i]) result_data[i] <= 16'h0a00 + 16'(i);
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // Priority and gating cases; flags cleared by software after each
    foreach (rows[i]) begin
      wr(`ARVIQ_OFF_IE, {16'h0, rows[i].ie});
      wr(`ARVIQ_OFF_CTL, {28'h0, rows[i].ctl});
      slot_overflow      <= rows[i].ov;
      conv_time_overflow <= rows[i].tov;
      glob_en_cmd        <= rows[i].glob_en;
      result_load        <= rows[i].ld;
      @(posedge mclk);
      result_load <= 16'h0;
      @(posedge mclk);
      rdr(`ARVIQ_OFF_IV);
      chk("vector", rd, {16'h0, rows[i].iv});
      chk("irq_req", {31'h0, irq_req}, {31'h0, rows[i].irq});
      chk("irq_taken", {31'h0, irq_seen}, {31'h0, rows[i].irq});
      wr(`ARVIQ_OFF_IFG, 32'h0);
    end
    // Each slot alone: flag, code, result read, clear on access
    wr(`ARVIQ_OFF_IE, 32'h0000ffff);
    slot_overflow      <= 1'b0;
    conv_time_overflow <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      result_load <= 16'h1 << n;
      @(posedge mclk);
      result_load <= 16'h0;
      rdr(`ARVIQ_OFF_IFG);
      chk("flags", rd, 32'h1 << n);
      rdr(`ARVIQ_OFF_IV);
      chk("vector", rd, 32'(6 + 2 * n));
      rdr(`ARVIQ_OFF_SLOT0 + 12'(4 * n));
      chk("slot", rd, {16'h0, result_data[n]});
      rdr(`ARVIQ_OFF_IFG);
      chk("flags", rd, 32'h0);
    end
    // Readback, strobe-less write, control readback, software flag write, read-only vector, unmapped place
    wr(`ARVIQ_OFF_IE, 32'h0000a5c3);
    rdr(`ARVIQ_OFF_IE);
    chk("enable", rd, 32'h0000a5c3);
    s_axi_wstrb <= 4'h0;
    wr(`ARVIQ_OFF_IE, 32'h00000000);
    s_axi_wstrb <= 4'hf;
    chk("strobe_resp", {30'h0, rsp}, {30'h0, `ARVIQ_RESP_OKAY});
    rdr(`ARVIQ_OFF_IE);
    chk("enable_strobe", rd, 32'h0000a5c3);
    rdr(`ARVIQ_OFF_CTL);
    chk("control", rd, 32'h00000008);
    wr(`ARVIQ_OFF_IFG, 32'h00000300);
    rdr(`ARVIQ_OFF_IV);
    chk("vector", rd, 32'h00000016);
    wr(`ARVIQ_OFF_IV, 32'h0000ffff);
    chk("vector_wr_resp", {30'h0, rsp}, {30'h0, `ARVIQ_RESP_SLVERR});
    rdr(`ARVIQ_OFF_IV);
    chk("vector_ro", rd, 32'h00000016);
    wr(`ARVIQ_OFF_IFG, 32'h0);
    rdr(`ARVIQ_OFF_IV);
    chk("vector", rd, 32'h0);
    rdr(12'h100);
    chk("unmapped", {rd[29:0], rsp}, {30'h0, `ARVIQ_RESP_SLVERR});
    // Second reset with state held
    wr(`ARVIQ_OFF_IFG, 32'h00000001);
    chk("irq_req_pre", {31'h0, irq_req}, 32'h1);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    chk("irq_req", {31'h0, irq_req}, 32'h0);
    rdr(`ARVIQ_OFF_IE);
    chk("enable_rst", rd, 32'h0);
    rdr(`ARVIQ_OFF_IFG);
    chk("flags_rst", rd, 32'h0);
    rdr(`ARVIQ_OFF_IV);
    chk("vector_rst", rd, 32'h0);
    give_verdict();
  end
endmodule
